//--- src/adiv_pkg.sv
`default_nettype none
// Shared constants of the antenna diversity controller.
package adiv_pkg;
   // Register byte offsets on the APB bus.
   localparam logic [7:0] ADIV_CTRL_OFF = 8'h00;
   localparam logic [7:0] ADIV_THRESH_OFF = 8'h04;
   localparam logic [7:0] ADIV_STATUS_OFF = 8'h08;
   // Control register fields.
   localparam int ADIV_TX_EN_BIT = 0;
   localparam int ADIV_RX_EN_BIT = 1;
   localparam int ADIV_SWAP_BIT = 2;
   localparam int ADIV_SEL_ROUTE_LSB = 4;
   localparam int ADIV_SELN_ROUTE_LSB = 8;
   localparam int ADIV_ROUTE_W = 2;
   // Threshold register fields.
   localparam int ADIV_ENERGY_LSB = 0;
   localparam int ADIV_QUAL_LSB = 8;
   localparam int ADIV_LEVEL_W = 8;
   // Status register fields.
   localparam int ADIV_CUR_BIT = 0;
   localparam int ADIV_LAST_TX_BIT = 1;
   localparam int ADIV_LAST_RX_BIT = 2;
   // Reset values.
   localparam logic ADIV_RST_ANT = 1'b0;
   localparam logic [1:0] ADIV_RST_ROUTE = 2'h0;
   localparam logic [7:0] ADIV_RST_ENERGY = 8'h00;
   localparam logic [7:0] ADIV_RST_QUAL = 8'h00;
   // Timing: sample interval and preamble window, both 40 us.
   localparam int ADIV_CLK_MHZ = 100;
   localparam int ADIV_SAMPLE_US = 40;
   localparam int ADIV_SAMPLE_CYC = ADIV_SAMPLE_US * ADIV_CLK_MHZ;
endpackage
`default_nettype wire

//--- src/adiv_interval.sv
`timescale 1ns/10ps
`default_nettype none
// Free-running divider that pulses once every CYCLES enabled clocks.
module adiv_interval #(
   parameter int unsigned CYCLES = adiv_pkg::ADIV_SAMPLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   output logic tick
);
   localparam int CW = $clog2(CYCLES);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   logic [CW-1:0] count;
   wire at_end = (count == LAST);

   // The counter wraps at the end of each interval and the tick marks it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
         tick <= 1'b0;
      end else if (ce) begin
         count <= at_end ? '0 : count + 1'b1;
         tick <= at_end;
      end
   end
endmodule
`default_nettype wire

//--- src/adiv_control.sv
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// RQ1: Two complementary select outputs, 10 or 01.
// RQ2: Each output routes to a chosen pin.
// RQ3: Separate transmit and receive diversity enables.
// RQ4: Missing acknowledgement sends retry on other antenna.
// RQ5: Toggle again before every further retry.
// RQ6: Sample channel energy every 40 us.
// RQ7: Low energy swaps only when idle.
// RQ8: Good preamble in last 40 us blocks swap.
// RQ9: Energy and quality thresholds are software writable.
// RQ10: Status shows last tx, last rx, current.
// RQ11: Software swap command toggles antenna immediately.
// RQ12: Reset selects fixed antenna, outputs stay complementary.
module adiv_control #(
   parameter int unsigned EW = adiv_pkg::ADIV_LEVEL_W,
   parameter int unsigned SAMPLE_CYC = adiv_pkg::ADIV_SAMPLE_CYC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic tx_start,
   input wire logic ack_missed,
   input wire logic ack_wait,
   input wire logic rx_busy,
   input wire logic rx_done,
   input wire logic [EW-1:0] energy_level,
   input wire logic preamble_det,
   input wire logic [EW-1:0] preamble_quality,
   output logic antenna_select_out,
   output logic antenna_select_out_n,
   output logic [2:0] sel_pin_en,
   output logic [2:0] sel_n_pin_en
);
   localparam int PW = $clog2(SAMPLE_CYC + 1);
   localparam logic [PW-1:0] WIN = PW'(SAMPLE_CYC);

   // Route code 0..2 picks one of three pins; 3 leaves the output unrouted.
   function automatic logic [2:0] route_decode(input logic [1:0] code);
      route_decode = (code == 2'h3) ? 3'h0 : 3'(3'h1 << code);
   endfunction

   logic tx_en;
   logic rx_en;
   logic [1:0] sel_route;
   logic [1:0] sel_n_route;
   logic [EW-1:0] energy_thresh;
   logic [EW-1:0] qual_thresh;
   logic ant;
   logic last_tx_ant;
   logic last_rx_ant;
   logic [PW-1:0] pre_age;
   logic sample_tick;

   // APB decode: the access phase ends one cycle after it starts.
   wire access = psel & penable;
   wire hit_ctrl = (paddr == adiv_pkg::ADIV_CTRL_OFF);
   wire hit_thresh = (paddr == adiv_pkg::ADIV_THRESH_OFF);
   wire hit_status = (paddr == adiv_pkg::ADIV_STATUS_OFF);
   wire hit_any = hit_ctrl | hit_thresh | hit_status;
   wire wr_take = access & pready & pwrite & ~pslverr;
   wire wr_ctrl = wr_take & hit_ctrl;
   wire wr_thresh = wr_take & hit_thresh;

   // Read data views; the swap bit always reads as zero.
   wire [31:0] ctrl_view = (32'(sel_route) << adiv_pkg::ADIV_SEL_ROUTE_LSB)
      | (32'(sel_n_route) << adiv_pkg::ADIV_SELN_ROUTE_LSB)
      | (32'(rx_en) << adiv_pkg::ADIV_RX_EN_BIT)
      | (32'(tx_en) << adiv_pkg::ADIV_TX_EN_BIT);
   wire [31:0] thresh_view = (32'(qual_thresh) << adiv_pkg::ADIV_QUAL_LSB)
      | (32'(energy_thresh) << adiv_pkg::ADIV_ENERGY_LSB);
   wire [31:0] status_view = (32'(last_rx_ant) << adiv_pkg::ADIV_LAST_RX_BIT)
      | (32'(last_tx_ant) << adiv_pkg::ADIV_LAST_TX_BIT)
      | (32'(ant) << adiv_pkg::ADIV_CUR_BIT); // RQ10
   wire [31:0] rd_data = hit_ctrl ? ctrl_view :
      hit_thresh ? thresh_view :
      hit_status ? status_view : 32'h0000_0000;

   // Swap sources; any of them in one cycle gives a single toggle.
   wire qual_pre = preamble_det & (preamble_quality > qual_thresh); // RQ8
   wire recent_pre = (pre_age != '0) | qual_pre; // RQ8
   wire low_energy = sample_tick & (energy_level < energy_thresh); // RQ6
   wire rx_idle = ~rx_busy & ~ack_wait & ~recent_pre; // RQ7
   wire rx_swap = rx_en & low_energy & rx_idle; // RQ3
   wire tx_swap = tx_en & ack_missed; // RQ4 RQ5
   wire man_swap = wr_ctrl & pwdata[adiv_pkg::ADIV_SWAP_BIT]; // RQ11
   wire next_ant = ant ^ (tx_swap | rx_swap | man_swap);

   // Energy sampling interval.
   adiv_interval #(
      .CYCLES(SAMPLE_CYC)
   ) u_sample (
      .pclk(pclk),
      .presetn(presetn),
      .ce(ce),
      .tick(sample_tick)
   );

   // APB answer: ready and error come one cycle into the access phase.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~hit_any;
         if (access & ~pready) begin
            prdata <= pwrite ? 32'h0000_0000 : rd_data;
         end
      end
   end

   // Software settings: enables, pin routes and thresholds.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_en <= 1'b0;
         rx_en <= 1'b0;
         sel_route <= adiv_pkg::ADIV_RST_ROUTE;
         sel_n_route <= adiv_pkg::ADIV_RST_ROUTE;
         energy_thresh <= EW'(adiv_pkg::ADIV_RST_ENERGY);
         qual_thresh <= EW'(adiv_pkg::ADIV_RST_QUAL);
      end else if (ce) begin
         if (wr_ctrl) begin
            tx_en <= pwdata[adiv_pkg::ADIV_TX_EN_BIT]; // RQ3
            rx_en <= pwdata[adiv_pkg::ADIV_RX_EN_BIT]; // RQ3
            sel_route <= pwdata[adiv_pkg::ADIV_SEL_ROUTE_LSB +: 2]; // RQ2
            sel_n_route <= pwdata[adiv_pkg::ADIV_SELN_ROUTE_LSB +: 2]; // RQ2
         end
         if (wr_thresh) begin
            energy_thresh <= pwdata[adiv_pkg::ADIV_ENERGY_LSB +: EW]; // RQ9
            qual_thresh <= pwdata[adiv_pkg::ADIV_QUAL_LSB +: EW]; // RQ9
         end
      end
   end

   // Preamble window: a good preamble blocks receive swaps for 40 us.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_age <= '0;
      end else if (ce) begin
         if (qual_pre) begin
            pre_age <= WIN; // RQ8
         end else if (pre_age != '0) begin
            pre_age <= pre_age - 1'b1;
         end
      end
   end

   // Antenna state and its complementary pair, both set on the same edge.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ant <= adiv_pkg::ADIV_RST_ANT; // RQ12
         antenna_select_out <= ~adiv_pkg::ADIV_RST_ANT; // RQ12
         antenna_select_out_n <= adiv_pkg::ADIV_RST_ANT; // RQ12
         last_tx_ant <= adiv_pkg::ADIV_RST_ANT;
         last_rx_ant <= adiv_pkg::ADIV_RST_ANT;
      end else if (ce) begin
         ant <= next_ant;
         antenna_select_out <= ~next_ant; // RQ1
         antenna_select_out_n <= next_ant; // RQ1
         if (tx_start) begin
            last_tx_ant <= ant; // RQ10
         end
         if (rx_done) begin
            last_rx_ant <= ant; // RQ10
         end
      end
   end

   // Pin enables follow the registered routes.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sel_pin_en <= 3'h1;
         sel_n_pin_en <= 3'h1;
      end else if (ce) begin
         sel_pin_en <= route_decode(sel_route); // RQ2
         sel_n_pin_en <= route_decode(sel_n_route); // RQ2
      end
   end

   // Checks on the antenna outputs and their causes, the antenna status and the APB answer.
   default clocking adiv_cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   pair_complement_a: assert property ( // RQ1
      antenna_select_out != antenna_select_out_n)
      else $error("Select outputs are not complementary.");

   route_onehot_a: assert property ( // RQ2
      ce && sel_route != 2'h3 |=> $countones(sel_pin_en) == 1)
      else $error("Routed output is not on exactly one pin.");

   tx_off_hold_a: assert property ( // RQ3
      ce && !tx_en && !rx_en && !man_swap
      |=> antenna_select_out == $past(antenna_select_out))
      else $error("Antenna changed with diversity off.");

   tx_retry_swap_a: assert property ( // RQ4
      ce && tx_en && ack_missed
      |=> antenna_select_out != $past(antenna_select_out))
      else $error("Retry did not move to the other antenna.");

   tx_second_retry_a: assert property ( // RQ5
      ce && tx_en && ack_missed && !rx_swap && !man_swap ##1
      ce && tx_en && ack_missed && !rx_swap && !man_swap
      |=> antenna_select_out == $past(antenna_select_out, 2))
      else $error("Second retry did not toggle again.");

   sample_period_a: assert property ( // RQ6
      ce && sample_tick |=> !sample_tick)
      else $error("Energy sample ticks too often.");

   rx_busy_block_a: assert property ( // RQ7
      ce && rx_busy && !tx_swap && !man_swap
      |=> antenna_select_out == $past(antenna_select_out))
      else $error("Antenna swapped during reception.");

   preamble_block_a: assert property ( // RQ8
      ce && qual_pre |=> pre_age == WIN ##1 recent_pre)
      else $error("Good preamble did not open block window.");

   thresh_write_a: assert property ( // RQ9
      ce && wr_thresh
      |=> energy_thresh == $past(pwdata[adiv_pkg::ADIV_ENERGY_LSB +: EW]))
      else $error("Energy threshold write not stored.");

   last_tx_a: assert property ( // RQ10
      ce && tx_start |=> last_tx_ant == $past(ant))
      else $error("Last transmit antenna not recorded.");

   manual_swap_a: assert property ( // RQ11
      ce && man_swap |=> antenna_select_out_n != $past(antenna_select_out_n))
      else $error("Manual swap did not toggle antenna.");

   route_onehot_n_a: assert property ( // RQ2
      ce && sel_n_route != 2'h3 |=> $countones(sel_n_pin_en) == 1)
      else $error("Inverse output is not on exactly one pin.");

   route_off_a: assert property ( // RQ2
      ce && sel_route == 2'h3 |=> sel_pin_en == 3'h0)
      else $error("Unrouted output still drives a pin.");

   stall_hold_a: assert property ( // RQ3
      !ce |=> antenna_select_out == $past(antenna_select_out))
      else $error("Antenna changed while clock enable was low.");

   rx_low_swap_a: assert property ( // RQ6
      ce && rx_en && sample_tick && energy_level < energy_thresh
      && !rx_busy && !ack_wait && pre_age == '0 && !qual_pre
      |=> antenna_select_out != $past(antenna_select_out))
      else $error("Low energy sample did not swap the antenna.");

   tick_only_a: assert property ( // RQ6
      ce && !sample_tick && !tx_swap && !man_swap
      |=> antenna_select_out == $past(antenna_select_out))
      else $error("Receive swap away from a sample tick.");

   ack_wait_block_a: assert property ( // RQ7
      ce && ack_wait && !tx_swap && !man_swap
      |=> antenna_select_out == $past(antenna_select_out))
      else $error("Antenna swapped while an acknowledgement was awaited.");

   window_block_a: assert property ( // RQ8
      ce && pre_age != '0 && !tx_swap && !man_swap
      |=> antenna_select_out == $past(antenna_select_out))
      else $error("Antenna swapped inside the preamble window.");

   qual_write_a: assert property ( // RQ9
      ce && wr_thresh
      |=> qual_thresh == $past(pwdata[adiv_pkg::ADIV_QUAL_LSB +: EW]))
      else $error("Quality threshold write not stored.");

   ready_pulse_a: assert property ( // RQ9
      ce && pready |=> !pready)
      else $error("Bus ready lasted more than one cycle.");

   unmapped_error_a: assert property ( // RQ9
      ce && access && !pready && !hit_any |=> pready && pslverr)
      else $error("Unmapped access did not answer with an error.");

   last_rx_a: assert property ( // RQ10
      ce && rx_done |=> last_rx_ant == $past(ant))
      else $error("Last receive antenna not recorded.");

   reset_default_a: assert property ( // RQ12
      $rose(presetn) |-> antenna_select_out_n == adiv_pkg::ADIV_RST_ANT)
      else $error("Reset did not select the default antenna.");
endmodule
`default_nettype wire

//--- test/adiv_switch.sv
`timescale 1ns/10ps
`default_nettype none
// Two-position RF switch model that reports which antenna is connected.
module adiv_switch (
   input wire logic ctl_a,
   input wire logic ctl_b,
   output logic position,
   output logic fault
);
   // Levels 10 connect antenna 0 and 01 connect antenna 1.
   // Equal levels leave the switch undefined, so they are flagged.
   assign position = ctl_b;
   assign fault = (ctl_a === ctl_b);
endmodule
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the antenna diversity controller.
module tb;
   typedef struct {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] q;
      logic e;
   } adiv_row_type;
   logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, se;
   logic [7:0] paddr, energy_level, preamble_quality;
   logic [31:0] pwdata, prdata, rd;
   logic tx_start, ack_missed, ack_wait, rx_busy, rx_done, preamble_det;
   logic sel, sel_n, pos, pos_q, flt, ant_q;
   logic [2:0] sel_pin_en, sel_n_pin_en;
   int err_count, tests_run, nsw, s;
   adiv_row_type rows [5] = '{
      '{8'h04, 32'hffffffff, 32'h0000ffff, 1'b0},
      '{8'h04, 32'h0000a55a, 32'h0000a55a, 1'b0},
      '{8'h00, 32'h00000130, 32'h00000130, 1'b0},
      '{8'h08, 32'hffffffff, 32'h00000000, 1'b0},
      '{8'h0c, 32'h00000001, 32'h00000000, 1'b1}};

   adiv_control #(.SAMPLE_CYC(8)) dut (.pclk(pclk), .presetn(presetn),
      .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tx_start(tx_start), .ack_missed(ack_missed),
      .ack_wait(ack_wait), .rx_busy(rx_busy), .rx_done(rx_done),
      .energy_level(energy_level), .preamble_det(preamble_det),
      .preamble_quality(preamble_quality), .antenna_select_out(sel),
      .antenna_select_out_n(sel_n), .sel_pin_en(sel_pin_en),
      .sel_n_pin_en(sel_n_pin_en));
   adiv_switch sw (.ctl_a(sel), .ctl_b(sel_n), .position(pos), .fault(flt));

   // Clock at 100 MHz.
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Counts antenna changes and flags a non-complementary pair.
   always @(posedge pclk) begin
      pos_q <= pos;
      if (pos !== pos_q) nsw <= nsw + 1;
      if (presetn === 1'b1 && flt === 1'b1) begin
         err_count++;
         $display("BAD %0t select pair equal", $time);
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] x);
      tests_run++;
      if (g !== x) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, g, x);
      end
   endtask

   // One APB transfer; waits for pready under a bounded count.
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk(32'h1, 32'h0);
   endtask

   // Counts antenna changes over two sample intervals after settling.
   task win(input int x);
      repeat (12) @(posedge pclk);
      s = nsw;
      repeat (16) @(posedge pclk);
      chk(32'(nsw - s), 32'(x));
   endtask

   function automatic logic [2:0] oh(input int r);
      return (r == 3) ? 3'h0 : 3'(1 << r);
   endfunction

   task results;
      $display("errors %0d checks %0d", err_count, tests_run);
      if (err_count == 0 && tests_run > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask

   // Watchdog against a hung handshake.
   initial begin
      #200000;
      err_count++;
      results();
   end

   // Main sequence: reset, register rows, then radio cases.
   initial begin
      {ce, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {tx_start, ack_missed, ack_wait, rx_busy, rx_done} = '0;
      {energy_level, preamble_det, preamble_quality} = '0;
      ce = 1'b1;
      err_count = 0;
      tests_run = 0;
      nsw = 0;
      repeat (6) @(posedge pclk);
      chk({24'h0, sel, sel_n, sel_pin_en, sel_n_pin_en}, 32'h89);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         chk({31'h0, se}, {31'h0, rows[i].e});
         apb(1'b0, rows[i].a, 32'h0);
         chk(rd, rows[i].q);
         chk({31'h0, se}, {31'h0, rows[i].e});
      end
      for (int r = 0; r < 4; r++) begin
         apb(1'b1, 8'h00, {22'h0, 2'(r + 1), 2'h0, 2'(r), 4'h0});
         repeat (2) @(posedge pclk);
         chk({26'h0, sel_pin_en, sel_n_pin_en},
             {26'h0, oh(r), oh((r + 1) % 4)});
      end
      apb(1'b1, 8'h00, 32'h1);
      s = nsw;
      ack_missed <= 1'b1;
      repeat (3) @(posedge pclk);
      ack_missed <= 1'b0;
      tx_start <= 1'b1;
      @(posedge pclk);
      tx_start <= 1'b0;
      repeat (3) @(posedge pclk);
      chk(32'(nsw - s), 32'h3);
      // A missed acknowledgement while the clock enable is low is ignored.
      s = nsw;
      ce <= 1'b0;
      ack_missed <= 1'b1;
      repeat (4) @(posedge pclk);
      {ce, ack_missed} <= 2'b10;
      repeat (3) @(posedge pclk);
      chk(32'(nsw - s), 32'h0);
      apb(1'b1, 8'h04, 32'h00008040);
      energy_level <= 8'h10;
      rx_busy <= 1'b1;
      ack_missed <= 1'b1;
      apb(1'b1, 8'h00, 32'h2);
      win(0);
      {rx_busy, ack_missed, ack_wait} <= 3'b001;
      win(0);
      ack_wait <= 1'b0;
      win(2);
      energy_level <= 8'h40;
      win(0);
      energy_level <= 8'h10;
      preamble_det <= 1'b1;
      preamble_quality <= 8'h81;
      win(0);
      preamble_quality <= 8'h80;
      win(2);
      preamble_det <= 1'b0;
      // Diversity off first, so that no sample tick adds a swap.
      apb(1'b1, 8'h00, 32'h0);
      repeat (2) @(posedge pclk);
      ant_q = pos;
      s = nsw;
      apb(1'b1, 8'h00, 32'h4);
      repeat (3) @(posedge pclk);
      chk(32'(nsw - s), 32'h1);
      chk({31'h0, pos}, {31'h0, ~ant_q});
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, 32'h0);
      rx_done <= 1'b1;
      @(posedge pclk);
      rx_done <= 1'b0;
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, {29'h0, ~ant_q, 1'b1, ~ant_q});
      apb(1'b1, 8'h00, 32'h4);
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, {29'h0, ~ant_q, 1'b1, ant_q});
      // A second reset in mid-run restores the default antenna.
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({24'h0, sel, sel_n, sel_pin_en, sel_n_pin_en}, 32'h89);
      presetn <= 1'b1;
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'h0);
      results();
   end
endmodule
`default_nettype wire
